/* File: src/fpe_pkg.sv */
package fpe_pkg;
	// CPU side map
	localparam logic [1:0]  FIXED_LO_WIN    = 2'b01;
	localparam logic [1:0]  PAGE_WIN        = 2'b10;
	localparam logic [1:0]  FIXED_HI_WIN    = 2'b11;
	localparam logic [2:0]  FIXED_LO_PAGE   = 3'h6;
	localparam logic [2:0]  FIXED_HI_PAGE   = 3'h7;
	localparam logic [1:0]  BOOT_TOP        = 2'b11;
	localparam logic [15:0] ERASED_WORD     = 16'hffff;
	localparam int          MODULE_WORDS    = 16384;
	// Device registers, two window pages per flash module
	localparam logic [15:0] FREEZE_ADDR     = 16'h00f4;
	localparam logic [15:0] SETUP_ADDR      = 16'h00f5;
	localparam logic [15:0] CTRL_ADDR       = 16'h00f7;
	localparam logic [15:0] UNPROT_ADDR     = 16'h00f0;
	localparam logic [7:0]  FREEZE_RST      = 8'h00;
	localparam logic [7:0]  SETUP_RST       = 8'h01;
	localparam logic [7:0]  CTRL_RST        = 8'h00;
	localparam int          FREEZE_BIT      = 0;
	localparam int          GUARD_BIT       = 0;
	localparam int          PGM_BIT         = 0;
	localparam int          ERA_BIT         = 1;
	localparam int          HV_BIT          = 3;
	localparam int          WAI_BIT         = 4;
	localparam int          UNPROT_BIT      = 4;
	// Timing
	localparam int          CLK_PERIOD_NS          = 40;
	localparam int          LATCH_TO_HV_DELAY_US   = 10;
	localparam int          HV_TO_WRITE_DELAY_US   = 5;
	localparam int          WORD_WRITE_MIN_US      = 30;
	localparam int          WORD_WRITE_MAX_US      = 40;
	localparam int          HV_HOLD_DELAY_US       = 5;
	localparam int          READ_RECOVERY_DELAY_US = 1;
	localparam int          CYCLES_PER_US          = (1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [23:0] LATCH_TO_HV_CYCLES     = 24'(LATCH_TO_HV_DELAY_US * CYCLES_PER_US);
	localparam logic [23:0] HV_TO_WRITE_CYCLES     = 24'(HV_TO_WRITE_DELAY_US * CYCLES_PER_US);
	localparam logic [23:0] WORD_WRITE_CYCLES      = 24'(WORD_WRITE_MIN_US * CYCLES_PER_US);
	localparam logic [23:0] HV_HOLD_CYCLES         = 24'(HV_HOLD_DELAY_US * CYCLES_PER_US);
	localparam logic [23:0] READ_RECOVERY_CYCLES   = 24'(READ_RECOVERY_DELAY_US * CYCLES_PER_US);
	localparam logic [7:0]  CYCLES_PER_US_W        = 8'(CYCLES_PER_US);
	// Host AXI4-Lite registers
	localparam int          AXI_AW        = 12;
	localparam logic [11:0] H_ADDR_OFS    = 12'h000;
	localparam logic [11:0] H_CMD_OFS     = 12'h004;
	localparam logic [11:0] H_RESULT_OFS  = 12'h008;
	localparam logic [11:0] H_MODE_OFS    = 12'h00c;
	localparam logic [1:0]  OP_READ       = 2'h0;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [1:0]  OP_WAIT       = 2'h2;
	localparam int          CMD_WORD_BIT  = 2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [2:0] {
		FPE_W_LATCH, FPE_W_HV, FPE_W_WORD, FPE_W_HOLD, FPE_W_RECOV, FPE_W_CUSTOM
	} fpe_wait_sel_t;
endpackage

/* File: src/fpe_bus_if.sv */
`timescale 1ns/10ps
interface fpe_bus_if;
	logic        req;
	logic        we;
	logic        word;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [2:0]  page;
	logic        expanded;
	logic        special;
	logic        wait_mode;
	logic        stop_mode;
	logic        ack;
	logic [15:0] rdata;
	logic        claimed;
	modport dev (input req, we, word, addr, wdata, page, expanded, special, wait_mode,
		stop_mode, output ack, rdata, claimed);
	modport host (output req, we, word, addr, wdata, page, expanded, special, wait_mode,
		stop_mode, input ack, rdata, claimed);
endinterface

/* File: src/fpe_delay_timer.sv */
`timescale 1ns/10ps
module fpe_delay_timer (
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	input  wire logic        start_i,
	input  wire logic [23:0] cycles_i,
	output logic             busy_o
);
	import fpe_pkg::*;

	typedef struct packed {
		logic [23:0] left;
		logic        busy;
	} fpe_tmr_t;

	fpe_tmr_t q;
	fpe_tmr_t d;

	////////////////////////////////////////////////////////////////////////
	// Down counter, a zero count still takes one cycle
	always_comb begin
		d = q;
		if (start_i) begin
			d.left = cycles_i;
			d.busy = 1'b1;
		end else if (q.busy) begin
			if (q.left <= 24'h000001) begin
				d.busy = 1'b0;
				d.left = 24'h000000;
			end else begin
				d.left = q.left - 24'h000001;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign busy_o = q.busy;
endmodule // fpe_delay_timer

/* File: src/fpe_flash_device.sv */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
// Contract
// - fixed array seen at 4000 and C000
// - paged window 8000, eight pages, top two fixed
// - expanded mode: arrays disabled, not claimed
// - register window paged per module
// - normal mode freeze bit written once
// - freeze set blocks setup register writes
// - guard resets one, held while busy/frozen
// - guard inhibits boot block program/erase
// - wait-halt bit stops module clock in wait
// - high voltage needs select and latched row
// - program and erase select mutually exclusive
// - misaligned word read takes extra cycle
// - writes ignored outside program/erase
// - erased ones; program clears bits only
// - rows of 32 aligned words
// - host: select, latch, 10us, HV, 5us
// - host: word write, wait 30-40us
// - guarded boot word writes ignored
// - host: clear select, 5us, clear HV, 1us
// - bulk erase sequence; boot spared if guarded
// - stop/wait entry aborts program/erase
// - global unprotect from shadow, gates all
module fpe_flash_device (
	input  wire logic  clock_i,
	input  wire logic  arst_n_i,
	input  wire logic  ce_i,
	fpe_bus_if.dev     bus,
	input  wire logic  shadow_unprotect_i,
	output logic [3:0] clk_halt_o,
	output logic [3:0] hv_on_o,
	output logic       unprotect_o
);
	import fpe_pkg::*;

	typedef enum logic {FPE_D_IDLE, FPE_D_MIS} fpe_dev_state_t;

	typedef struct packed {
		fpe_dev_state_t  st;
		logic            ack;
		logic [15:0]     rdata;
		logic            claimed;
		logic [7:0]      hi;
		logic [15:0]     next_a;
		logic [3:0]      freeze;
		logic [3:0]      frz_done;
		logic [3:0]      guard;
		logic [3:0]      wai;
		logic [3:0]      hv;
		logic [3:0]      era;
		logic [3:0]      program_select;
		logic [3:0]      latched;
		logic [3:0]      halt;
		logic [3:0][8:0] row;
		logic            unprot;
		logic            loaded;
		logic            sleep;
	} fpe_dev_t;

	fpe_dev_t    q;
	fpe_dev_t    d;
	logic [15:0] mem [0:4*MODULE_WORDS-1];
	logic        mem_we;
	logic [15:0] mem_idx;
	logic [15:0] mem_val;
	logic        erase_go;
	logic [1:0]  erase_mod;
	logic        erase_keep_boot;

	// CPU address to {hit, physical byte address}
	function automatic logic [17:0] fpe_map(input logic [15:0] a, input logic [2:0] pg);
		case (a[15:14])
			FIXED_LO_WIN: fpe_map = {1'b1, FIXED_LO_PAGE, a[13:0]};
			FIXED_HI_WIN: fpe_map = {1'b1, FIXED_HI_PAGE, a[13:0]};
			PAGE_WIN:     fpe_map = {1'b1, pg, a[13:0]};
			default:      fpe_map = 18'h00000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus access, register file and sequence interlocks
	always_comb begin
		logic [17:0] mp;
		logic [17:0] mp2;
		logic [1:0]  m;
		logic [1:0]  am;
		logic        hit;
		logic        boot;
		logic [8:0]  row;
		logic [15:0] w;
		logic [7:0]  wd;
		logic        entry;
		mp = fpe_map(bus.addr, bus.page);
		mp2 = fpe_map(q.next_a, bus.page);
		m = bus.page[2:1];
		am = mp[16:15];
		hit = mp[17] && !bus.expanded;
		boot = (mp[14:13] == BOOT_TOP);
		row = mp[14:6];
		w = mem[mp[16:1]];
		wd = bus.wdata[7:0];
		entry = (bus.wait_mode || bus.stop_mode) && !q.sleep;
		d = q;
		d.ack = 1'b0;
		d.sleep = bus.wait_mode || bus.stop_mode;
		mem_we = 1'b0;
		mem_idx = mp[16:1];
		mem_val = bus.wdata;
		erase_go = 1'b0;
		erase_mod = m;
		erase_keep_boot = q.guard[m];
		// Shadow bit caught on the first enabled edge after release
		if (!q.loaded) begin
			d.loaded = 1'b1;
			d.unprot = shadow_unprotect_i;
		end
		case (q.st)
			FPE_D_IDLE: begin
				if (bus.req && !q.ack) begin
					d.ack = 1'b1;
					d.rdata = 16'h0000;
					d.claimed = 1'b1;
					if (!bus.we) begin
						if (bus.addr == FREEZE_ADDR) begin
							d.rdata = {15'h0000, q.freeze[m]};
						end else if (bus.addr == SETUP_ADDR) begin
							d.rdata = {15'h0000, q.guard[m]};
						end else if (bus.addr == CTRL_ADDR) begin
							d.rdata = {11'h000, q.wai[m], q.hv[m], 1'b0, q.era[m], q.program_select[m]};
						end else if (bus.addr == UNPROT_ADDR) begin
							d.rdata = {11'h000, q.unprot, 4'h0};
						end else if (!hit) begin
							d.claimed = 1'b0;
						end else if (!bus.word) begin
							d.rdata = {8'h00, mp[0] ? w[7:0] : w[15:8]};
						end else if (!mp[0]) begin
							d.rdata = w;
						end else begin
							// Second half lies in the next word, maybe another page
							d.ack = 1'b0;
							d.rdata = q.rdata;
							d.claimed = q.claimed;
							d.hi = w[7:0];
							d.next_a = bus.addr + 16'h0001;
							d.st = FPE_D_MIS;
						end
					end else if (bus.addr == FREEZE_ADDR) begin
						if (bus.special || !q.frz_done[m]) begin
							d.freeze[m] = wd[FREEZE_BIT];
							d.frz_done[m] = 1'b1;
						end
					end else if (bus.addr == SETUP_ADDR) begin
						if (!q.freeze[m] && !(q.hv[m] || q.program_select[m] || q.era[m])) begin
							d.guard[m] = wd[GUARD_BIT];
						end
					end else if (bus.addr == CTRL_ADDR) begin
						d.wai[m] = wd[WAI_BIT];
						// A write asking for both selects changes neither
						if (!(wd[PGM_BIT] && wd[ERA_BIT])) begin
							d.program_select[m] = wd[PGM_BIT];
							d.era[m] = wd[ERA_BIT];
						end
						if (!wd[HV_BIT]) begin
							d.hv[m] = 1'b0;
						end else if ((q.program_select[m] || q.era[m]) && q.latched[m] && q.unprot) begin
							d.hv[m] = 1'b1;
						end
						// Erase is carried out when the select drops under high voltage
						if (q.era[m] && !d.era[m] && q.hv[m] && q.latched[m] && q.unprot) begin
							erase_go = 1'b1;
						end
						if (!d.program_select[m] && !d.era[m]) begin
							d.latched[m] = 1'b0;
						end
					end else if (bus.addr == UNPROT_ADDR) begin
						if (bus.special || !wd[UNPROT_BIT]) begin
							d.unprot = wd[UNPROT_BIT];
						end
					end else if (!hit) begin
						d.claimed = 1'b0;
					end else if (q.era[am] && !q.hv[am]) begin
						d.latched[am] = q.unprot;
					end else if (q.program_select[am] && bus.word && !mp[0] && q.unprot) begin
						if (!q.hv[am]) begin
							d.latched[am] = 1'b1;
							d.row[am] = row;
						end else if (q.latched[am] && q.row[am] == row
							&& !(q.guard[am] && boot)) begin
							mem_we = 1'b1;
						end
					end
					// Anything else to the array is dropped
				end
			end
			FPE_D_MIS: begin
				d.ack = 1'b1;
				d.rdata = {q.hi, (mp2[17] && !bus.expanded) ? mem[mp2[16:1]][15:8] : 8'h00};
				d.claimed = 1'b1;
				d.st = FPE_D_IDLE;
			end
			default: begin
				d.st = FPE_D_IDLE;
			end
		endcase
		// Sleep entry kills any operation at once; user must not rely on it
		if (entry) begin
			d.program_select = 4'h0;
			d.era = 4'h0;
			d.hv = 4'h0;
			d.latched = 4'h0;
			mem_we = 1'b0;
			erase_go = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			d.halt[i] = bus.wait_mode && d.wai[i];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			q.guard <= {4{SETUP_RST[GUARD_BIT]}};
			q.freeze <= {4{FREEZE_RST[FREEZE_BIT]}};
			q.wai <= {4{CTRL_RST[WAI_BIT]}};
			q.st <= FPE_D_IDLE;
		end else if (ce_i) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array cells: no reset, contents are nonvolatile
	always_ff @(posedge clock_i) begin
		if (ce_i) begin
			if (mem_we) begin
				mem[mem_idx] <= mem[mem_idx] & mem_val;
			end
			if (erase_go) begin
				for (int j = 0; j < MODULE_WORDS; j++) begin
					if (!(erase_keep_boot && j[13:12] == BOOT_TOP)) begin
						mem[{erase_mod, 14'(j)}] <= ERASED_WORD;
					end
				end
			end
		end
	end

	// Outputs straight from state
	assign bus.ack = q.ack;
	assign bus.rdata = q.rdata;
	assign bus.claimed = q.claimed;
	assign clk_halt_o = q.halt;
	assign hv_on_o = q.hv;
	assign unprotect_o = q.unprot;
endmodule // fpe_flash_device

/* File: src/fpe_flash_host.sv */
`timescale 1ns/10ps
module fpe_flash_host (
	input  wire logic                      clock_i,
	input  wire logic                      arst_n_i,
	input  wire logic                      ce_i,
	fpe_bus_if.host                        bus,
	input  wire logic [fpe_pkg::AXI_AW-1:0] s_axi_awaddr_i,
	input  wire logic                      s_axi_awvalid_i,
	output logic                           s_axi_awready_o,
	input  wire logic [31:0]               s_axi_wdata_i,
	input  wire logic [3:0]                s_axi_wstrb_i,
	input  wire logic                      s_axi_wvalid_i,
	output logic                           s_axi_wready_o,
	output logic [1:0]                     s_axi_bresp_o,
	output logic                           s_axi_bvalid_o,
	input  wire logic                      s_axi_bready_i,
	input  wire logic [fpe_pkg::AXI_AW-1:0] s_axi_araddr_i,
	input  wire logic                      s_axi_arvalid_i,
	output logic                           s_axi_arready_o,
	output logic [31:0]                    s_axi_rdata_o,
	output logic [1:0]                     s_axi_rresp_o,
	output logic                           s_axi_rvalid_o,
	input  wire logic                      s_axi_rready_i
);
	import fpe_pkg::*;

	typedef enum logic [1:0] {FPE_H_IDLE, FPE_H_BUS, FPE_H_WAIT} fpe_hst_state_t;

	typedef struct packed {
		fpe_hst_state_t st;
		logic [15:0]    addr;
		logic [15:0]    wdata;
		logic [6:0]     mode;
		logic [15:0]    rdata;
		logic           claimed;
		logic           req;
		logic           we;
		logic           word;
		logic           tstart;
		logic [23:0]    tcycles;
		logic           awready;
		logic           wready;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           aw_have;
		logic           w_have;
		logic [11:0]    awaddr;
		logic [31:0]    wd;
		logic [3:0]     wstrb;
		logic           arready;
		logic           rvalid;
		logic [1:0]     rresp;
		logic [31:0]    rdata_axi;
	} fpe_hst_t;

	fpe_hst_t q;
	fpe_hst_t d;
	logic     tbusy;

	// Register offset decode, shared by reads and writes
	function automatic logic fpe_mapped(input logic [11:0] a);
		fpe_mapped = (a == H_ADDR_OFS) || (a == H_CMD_OFS) || (a == H_RESULT_OFS)
			|| (a == H_MODE_OFS);
	endfunction

	// Timed waits keep the program/erase spacing on the far side
	fpe_delay_timer u_timer (
		.clock_i  (clock_i),
		.arst_n_i (arst_n_i),
		.ce_i     (ce_i),
		.start_i  (q.tstart),
		.cycles_i (q.tcycles),
		.busy_o   (tbusy)
	);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave and command sequencer
	always_comb begin
		logic busy;
		busy = (q.st != FPE_H_IDLE) || q.tstart;
		d = q;
		d.tstart = 1'b0;
		if (s_axi_awvalid_i && q.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && q.wready) begin
			d.w_have = 1'b1;
			d.wd = s_axi_wdata_i;
			d.wstrb = s_axi_wstrb_i;
		end
		if (q.bvalid && s_axi_bready_i) begin
			d.bvalid = 1'b0;
		end
		// Write takes effect once address and data are both held
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = fpe_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (q.awaddr == H_ADDR_OFS) begin
				// Low half is the bus address, high half the data, each by its lanes
				if (q.wstrb[1:0] != 2'b00) begin
					d.addr = q.wd[15:0];
				end
				if (q.wstrb[3:2] != 2'b00) begin
					d.wdata = q.wd[31:16];
				end
			end else if (q.awaddr == H_MODE_OFS) begin
				d.mode = q.wd[6:0];
			end else if (q.awaddr == H_CMD_OFS && !busy) begin
				// Commands while busy are dropped; software polls busy
				d.word = q.wd[CMD_WORD_BIT];
				if (q.wd[1:0] == OP_WAIT) begin
					d.tstart = 1'b1;
					d.st = FPE_H_WAIT;
					case (fpe_wait_sel_t'(q.wd[6:4]))
						FPE_W_LATCH:  d.tcycles = LATCH_TO_HV_CYCLES;
						FPE_W_HV:     d.tcycles = HV_TO_WRITE_CYCLES;
						FPE_W_WORD:   d.tcycles = WORD_WRITE_CYCLES;
						FPE_W_HOLD:   d.tcycles = HV_HOLD_CYCLES;
						FPE_W_RECOV:  d.tcycles = READ_RECOVERY_CYCLES;
						default:      d.tcycles = q.wd[31:16] * CYCLES_PER_US_W;
					endcase
				end else begin
					d.we = (q.wd[1:0] == OP_WRITE);
					d.req = 1'b1;
					d.st = FPE_H_BUS;
				end
			end
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		// Read channel
		if (q.rvalid && s_axi_rready_i) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = fpe_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr_i)
				H_ADDR_OFS:   d.rdata_axi = {q.wdata, q.addr};
				H_CMD_OFS:    d.rdata_axi = {31'h00000000, busy};
				H_RESULT_OFS: d.rdata_axi = {14'h0000, busy, q.claimed, q.rdata};
				H_MODE_OFS:   d.rdata_axi = {25'h0000000, q.mode};
				default:      d.rdata_axi = 32'h00000000;
			endcase
		end
		d.arready = !d.rvalid;
		// Device bus: request held until the one-cycle answer
		case (q.st)
			FPE_H_IDLE: begin
			end
			FPE_H_BUS: begin
				if (bus.ack) begin
					d.req = 1'b0;
					d.rdata = bus.rdata;
					d.claimed = bus.claimed;
					d.st = FPE_H_IDLE;
				end
			end
			FPE_H_WAIT: begin
				if (!tbusy && !q.tstart) begin
					d.st = FPE_H_IDLE;
				end
			end
			default: begin
				d.st = FPE_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			q.st <= FPE_H_IDLE;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign bus.req = q.req;
	assign bus.we = q.we;
	assign bus.word = q.word;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
	assign bus.expanded = q.mode[0];
	assign bus.special = q.mode[1];
	assign bus.wait_mode = q.mode[2];
	assign bus.stop_mode = q.mode[3];
	assign bus.page = q.mode[6:4];
	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rvalid_o = q.rvalid;
	assign s_axi_rresp_o = q.rresp;
	assign s_axi_rdata_o = q.rdata_axi;
endmodule // fpe_flash_host

/* File: tb/fpe_asserts.sv */
`timescale 1ns/10ps
module fpe_asserts (
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic        word,
	input  wire logic [15:0] addr,
	input  wire logic        expanded,
	input  wire logic        wait_mode,
	input  wire logic        stop_mode,
	input  wire logic        ack,
	input  wire logic        claimed,
	input  wire logic [15:0] rdata,
	input  wire logic [3:0]  hv_on_o,
	input  wire logic [3:0]  clk_halt_o,
	input  wire logic        unprotect_o
);
	// Odd word reads into the arrays cost one more cycle
	wire odd = word & addr[0] & ~we & (addr[15:14] != 2'b00);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	//////////////////////////////////////////////////////////////////////////////
	// Device answer timing
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_aligned_time: assert property ($rose(req) && !odd |=> ack)
		else $error("aligned access not answered next cycle");
	a_misalign_time: assert property ($rose(req) && odd && !expanded |=> !ack ##1 ack)
		else $error("misaligned read not two cycles");
	a_rdata_hold: assert property (!ack ##1 !ack |-> $stable(rdata))
		else $error("read data moved without answer");
	// Mode and protection
	a_expanded_off: assert property (ack && expanded && addr[15:14] != 2'b00 |-> !claimed)
		else $error("array answered in expanded mode");
	a_hv_protect: assert property ((hv_on_o & ~$past(hv_on_o)) != 4'h0 |-> unprotect_o)
		else $error("high voltage while protected");
	a_halt_wait: assert property (clk_halt_o != 4'h0 |-> $past(wait_mode))
		else $error("module clock halted outside wait");
	a_abort_entry: assert property ($rose(wait_mode | stop_mode) |-> ##[1:2] hv_on_o == 4'h0)
		else $error("high voltage kept after wait or stop entry");
	// Host holds its request
	a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
		else $error("request changed before answer");
	c_odd: cover property ($rose(req) && odd);
	c_unclaimed: cover property (ack && !claimed);
	c_hv: cover property (hv_on_o != 4'h0);
endmodule // fpe_asserts

/* File: tb/flash_array_program_erase_control_test.sv */
`timescale 1ns/10ps
module flash_array_program_erase_control_test;
	import fpe_pkg::*;
	localparam logic [31:0] RB = 32'h0, WB = 32'h1, RW = 32'h4, WW = 32'h5;
	logic        clock_i = 0, arst_n_i = 0, shd = 1, chk_on = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, unprot;
	logic [1:0]  bresp, rresp;
	logic [3:0]  halt, hv;
	logic [15:0] rnd;
	logic [35:0] q;
	logic [35:0] expq[$];
	int          err_total = 0, n_tests = 0, cyc = 0, seed = 9620;
	fpe_bus_if bus();
	fpe_flash_device u_fpe_flash_device (.clock_i, .arst_n_i, .ce_i(1'b1), .bus(bus),
		.shadow_unprotect_i(shd), .clk_halt_o(halt), .hv_on_o(hv), .unprotect_o(unprot));
	fpe_flash_host u_fpe_flash_host (.clock_i, .arst_n_i, .ce_i(1'b1), .bus(bus),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
	fpe_asserts u_fpe_asserts (.clock_i, .arst_n_i, .req(bus.req), .we(bus.we),
		.word(bus.word), .addr(bus.addr), .expanded(bus.expanded),
		.wait_mode(bus.wait_mode), .stop_mode(bus.stop_mode), .ack(bus.ack),
		.claimed(bus.claimed), .rdata(bus.rdata), .hv_on_o(hv), .clk_halt_o(halt),
		.unprotect_o(unprot));
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clock_i = ~clock_i;
	end
	task automatic conclude();
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			conclude();
		end
	end
	// Write holds bready from the start, so the answer edge ends it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clock_i);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clock_i);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		d = rdata;
		rready <= 0;
	endtask
	// One device access through the host, polled until idle
	task automatic cmd(input logic [15:0] a, input logic [15:0] d, input logic [31:0] c);
		logic [31:0] v;
		wr(H_ADDR_OFS, {d, a});
		wr(H_CMD_OFS, c);
		do rd(H_CMD_OFS, v); while (v[0] !== 1'b0);
	endtask
	task automatic wt(input logic [2:0] s, input logic [15:0] us);
		cmd(16'h0, 16'h0, {us, 9'h0, s, 2'b0, OP_WAIT});
	endtask
	task automatic chkrd(input logic [11:0] a, input logic [16:0] m, input logic [16:0] e,
		input logic [1:0] r);
		logic [31:0] v;
		expq.push_back({m, e, r});
		chk_on <= 1;
		rd(a, v);
		chk_on <= 0;
	endtask
	task automatic chk(input logic [15:0] a, input logic w, input logic [16:0] e);
		cmd(a, 16'h0, w ? RW : RB);
		chkrd(H_RESULT_OFS, w ? 17'h1ffff : 17'h100ff, e, RESP_OKAY);
	endtask
	// Device side pins: {unprotect, high voltage, clock halt}
	task automatic chkpin(input logic [8:0] e);
		n_tests++;
		if ({unprot, hv, halt} !== e) begin
			$display("MISMATCH pins exp %h got %h", e, {unprot, hv, halt});
			err_total++;
		end
	endtask
	// Latch with all ones so the row select write cannot clear a bit
	task automatic prog(input logic [15:0] a, input logic [15:0] d);
		cmd(CTRL_ADDR, 16'h01, WB);
		cmd(a, ERASED_WORD, WW);
		wt(3'd0, 16'h0);
		cmd(CTRL_ADDR, 16'h09, WB);
		chkpin(9'h120);
		wt(3'd1, 16'h0);
		cmd(a, d, WW);
		wt(3'd2, 16'h0);
		cmd(CTRL_ADDR, 16'h08, WB);
		wt(3'd3, 16'h0);
		cmd(CTRL_ADDR, 16'h00, WB);
		wt(3'd4, 16'h0);
	endtask
	// Results are judged here as they come back, oldest note first
	always @(posedge clock_i) begin
		if (chk_on && rvalid && rready) begin
			q = expq.pop_front();
			n_tests++;
			if ({rdata[16:0] & q[35:19], rresp} !== q[18:0])
				$display("MISMATCH result exp %h got %h", q[18:0], {rdata[16:0], rresp});
			if ({rdata[16:0] & q[35:19], rresp} !== q[18:0]) err_total++;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		rnd = 16'($random(seed));
		repeat (10) @(posedge clock_i);
		arst_n_i <= 1;
		repeat (2) @(posedge clock_i);
		wr(H_MODE_OFS, 32'h20);
		chkrd(12'h010, 17'h1ffff, 17'h0, RESP_SLVERR);
		chk(FREEZE_ADDR, 0, {9'h100, FREEZE_RST});
		chk(SETUP_ADDR, 0, {9'h100, SETUP_RST});
		cmd(CTRL_ADDR, 16'h03, WB);
		chk(CTRL_ADDR, 0, {9'h100, CTRL_RST});
		cmd(CTRL_ADDR, 16'h08, WB);
		chk(CTRL_ADDR, 0, 17'h10000);
		cmd(SETUP_ADDR, 16'h00, WB);
		chk(SETUP_ADDR, 0, 17'h10000);
		// Bulk clear of module one with its boot block open
		cmd(CTRL_ADDR, 16'h02, WB);
		cmd(16'h8000, 16'h0, WW);
		wt(3'd0, 16'h0);
		cmd(CTRL_ADDR, 16'h0a, WB);
		wt(3'd5, 16'd20);
		cmd(CTRL_ADDR, 16'h08, WB);
		wt(3'd3, 16'h0);
		cmd(CTRL_ADDR, 16'h00, WB);
		wt(3'd4, 16'h0);
		chk(16'h8000, 1, {1'b1, ERASED_WORD});
		prog(16'h8000, rnd);
		chk(16'h8000, 1, {1'b1, rnd});
		cmd(16'h8000, 16'h0, WW);
		chk(16'h8000, 1, {1'b1, rnd});
		chk(16'h8001, 1, {1'b1, rnd[7:0], 8'hff});
		chk(16'h8001, 0, {9'h100, rnd[7:0]});
		// Odd page boot block, cleared above, now guarded
		cmd(SETUP_ADDR, 16'h01, WB);
		wr(H_MODE_OFS, 32'h30);
		chk(16'ha000, 1, {1'b1, ERASED_WORD});
		prog(16'ha000, 16'h0000);
		chk(16'ha000, 1, {1'b1, ERASED_WORD});
		cmd(CTRL_ADDR, 16'h01, WB);
		cmd(SETUP_ADDR, 16'h00, WB);
		chk(SETUP_ADDR, 0, 17'h10001);
		wr(H_MODE_OFS, 32'h34);
		chk(CTRL_ADDR, 0, 17'h10000);
		cmd(CTRL_ADDR, 16'h10, WB);
		chkpin(9'h102);
		wr(H_MODE_OFS, 32'h30);
		chk(CTRL_ADDR, 0, 17'h10010);
		cmd(FREEZE_ADDR, 16'h01, WB);
		cmd(FREEZE_ADDR, 16'h00, WB);
		chk(FREEZE_ADDR, 0, 17'h10001);
		cmd(SETUP_ADDR, 16'h00, WB);
		chk(SETUP_ADDR, 0, 17'h10001);
		wr(H_MODE_OFS, 32'h31);
		chk(16'ha000, 1, 17'h0);
		// Second reset with the shadow unprotect bit cleared
		arst_n_i <= 0;
		shd <= 0;
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1;
		repeat (2) @(posedge clock_i);
		cmd(CTRL_ADDR, 16'h01, WB);
		cmd(16'h8000, ERASED_WORD, WW);
		cmd(CTRL_ADDR, 16'h09, WB);
		chk(CTRL_ADDR, 0, 17'h10001);
		chkpin(9'h000);
		// Normal mode may not reopen; special mode may
		cmd(UNPROT_ADDR, 16'h10, WB);
		chk(UNPROT_ADDR, 0, 17'h10000);
		wr(H_MODE_OFS, 32'h02);
		cmd(UNPROT_ADDR, 16'h10, WB);
		chk(UNPROT_ADDR, 0, 17'h10010);
		chkpin(9'h100);
		conclude();
	end
endmodule // flash_array_program_erase_control_test
